// >>> core/dog_consts.vh
/*
 * Constants for the watchdog, sleep-mode and warm-up controller:
 * register indices, field positions, reset values, state codes and
 * timing figures.
 * Assumes inclusion by its bare name from files under core/.
 */
`ifndef DOG_CONSTS_VH
`define DOG_CONSTS_VH

// ************************************
// Clock and timing
// ************************************
`define CLK_PERIOD_NS   8
`define DOG_BASE_NS     500000
`define DOG_BASE_CYC    ((`DOG_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARM_POR_RC     4096
`define WARM_POR_XTAL   16384
`define WARM_PAD_RC     256
`define WARM_PAD_XTAL   1024
`define WARM_STOP_RC    256
`define WARM_STOP_XTAL  16384

// ************************************
// Register map (index; byte address is index * 4)
// ************************************
`define IDX_T0M         10'h002
`define IDX_DOG         10'h01a
`define IDX_STAT        10'h020
`define DOG_RESTART_BIT 3
`define T0M_RESET       3'h0
`define FLAG_RESET      1'b1
`define CLK_OPT_RC_BIT  1

// ************************************
// States
// ************************************
`define ST_WARM         2'h0
`define ST_RUN          2'h1
`define ST_HALT         2'h2
`define ST_STOP         2'h3

`endif

// >>> core/watchdog_sleep_warmup_ctrl.v
/*
 * Watchdog with reset-cause flag, HALT/STOP control and oscillator
 * warm-up sequencing, reached over an APB slave port.
 * Assumes a single 125 MHz clock standing in for the system clock,
 * synchronous inputs, and a CPU that obeys core_reset and cpu_run.
 */
// The APB register port was left to the implementer.
// Notes on behaviour
// - Watchdog counts down; frozen in STOP
// - Watchdog overflow forces full device reset
// - Build-time option enables watchdog, default off
// - Writing one to bit 3 restarts count
// - Unscaled time-out exceeds half a millisecond
// - Three-bit prescale code picks divide ratio
// - Watchdog shares Timer0 prescale setting live
// - Flag cleared only by watchdog reset
// - Flag reads one after other resets, STOP wakes
// - Counter cleared at power-on, flag set to one
// - Counter cleared on every STOP wake
// - HALT stops CPU; peripherals keep running
// - STOP halts whole chip and oscillator
// - HALT wakes on any interrupt; STOP port/external
// - Wake runs service routine, then next instruction
// - Power-on warm-up 4096 RC, 16384 crystal
// - Pad reset warm-up 256 RC, 1024 crystal
// - STOP wake warm-up 256 RC, 16384 crystal
// - Two-bit clock option picks oscillator, warm-up
// - Base time-out same for every clock source
`timescale 1ns/1ps
`default_nettype none
`include "dog_consts.vh"

module watchdog_sleep_warmup_ctrl #(
    parameter DOG_BASE_CYCLES = `DOG_BASE_CYC,
    parameter WARM_POR_XTAL   = `WARM_POR_XTAL,
    parameter WARM_POR_RC     = `WARM_POR_RC,
    parameter WARM_PAD_XTAL   = `WARM_PAD_XTAL,
    parameter WARM_PAD_RC     = `WARM_PAD_RC,
    parameter WARM_STOP_XTAL  = `WARM_STOP_XTAL,
    parameter WARM_STOP_RC    = `WARM_STOP_RC
) (
    // Clock and resets
    input  wire        clk,
    input  wire        reset,
    input  wire        pad_reset,
    // Build-time options
    input  wire        dog_enable_opt,
    input  wire [1:0]  clock_source_option,
    // CPU sleep requests and interrupts
    input  wire        halt_exec,
    input  wire        stop_exec,
    input  wire        any_irq,
    input  wire        port_irq,
    input  wire        ext_irq,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Device control
    output reg         core_reset,
    output reg         cpu_run,
    output reg         periph_run,
    output reg         osc_run,
    output reg         wake_to_isr,
    output reg  [2:0]  timer0_prescale
);

    // ************************************
    // Sequencer state
    // ************************************
    reg  [1:0]  state;
    reg  [14:0] warm_cnt;

    // ************************************
    // Watchdog state
    // ************************************
    // Prescale count runs free; the watchdog only uses its tick
    reg  [16:0] dog_cnt;
    reg         dog_flag;
    reg  [9:0]  psc_cnt;

    // ************************************
    // Latched options and wake marker
    // ************************************
    // Caught while reset is held, never written afterwards
    reg         dog_en;
    reg  [1:0]  clk_opt;
    // Set on a STOP wake, so warm-up ends with a service strobe
    reg         from_stop;

    // ************************************
    // Read path
    // ************************************
    reg  [31:0] next_prdata;
    reg         addr_hit;

    // ************************************
    // APB and clock-option decode strobes
    // ************************************
    wire        is_rc;
    wire        acc;
    wire        apb_wr;
    wire [9:0]  word_idx;
    wire        aligned;
    wire        sel_t0m;
    wire        sel_dog;
    wire        sel_stat;

    // ************************************
    // Watchdog, wake and reset strobes
    // ************************************
    wire        dog_live;
    wire [3:0]  psc_sh;
    wire [9:0]  psc_mask;
    wire        psc_tick;
    wire        dog_over;
    wire        restart;
    wire        stop_wake;
    wire        halt_wake;
    wire        any_rst;

    // ************************************
    // Prescaler ratio lookup
    // ************************************
    // Shift is log2 of the ratio; the slow codes skip powers
    function [3:0] ratio_shift;
        input [2:0] code;
        begin
            case (code)
                3'h7:    ratio_shift = 4'h0;
                3'h6:    ratio_shift = 4'h1;
                3'h5:    ratio_shift = 4'h2;
                3'h4:    ratio_shift = 4'h3;
                3'h3:    ratio_shift = 4'h5;
                3'h2:    ratio_shift = 4'h7;
                3'h1:    ratio_shift = 4'h9;
                default: ratio_shift = 4'ha;
            endcase
        end
    endfunction

    // ************************************
    // Decode
    // ************************************
    // Codes 10 and 11 both run the RC oscillator
    assign is_rc     = clk_opt[`CLK_OPT_RC_BIT];
    // Only the answering edge counts as a transfer
    assign acc       = psel & penable & pready;
    assign apb_wr    = acc & pwrite;
    assign word_idx  = paddr[11:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign sel_t0m   = aligned & (word_idx == `IDX_T0M);
    assign sel_dog   = aligned & (word_idx == `IDX_DOG);
    assign sel_stat  = aligned & (word_idx == `IDX_STAT);

    // ************************************
    // Prescale tick
    // ************************************
    // Mask is all ones below the shift, so a code change acts at once
    assign psc_sh    = ratio_shift(timer0_prescale);
    assign psc_mask  = ~(10'h3ff << psc_sh);
    assign psc_tick  = ((psc_cnt & psc_mask) == psc_mask);

    // ************************************
    // Watchdog, wake and reset decode
    // ************************************
    // STOP is excluded, so the count makes no progress there
    assign dog_live  = dog_en & ((state == `ST_RUN) | (state == `ST_HALT));
    assign dog_over  = dog_live & psc_tick & (dog_cnt == 17'h0);
    // Writing zero to the restart bit does nothing
    assign restart   = apb_wr & sel_dog & pwdata[`DOG_RESTART_BIT];
    assign stop_wake = (state == `ST_STOP) & (port_irq | ext_irq);
    assign halt_wake = (state == `ST_HALT) & any_irq;
    // Overflow takes the whole pad-reset path
    assign any_rst   = pad_reset | dog_over;

    // ************************************
    // Shared prescaler counter
    // ************************************
    always @(posedge clk) begin
        if (reset | any_rst) begin
            // A restart leaves this count running, so the first tick after one may come early
            psc_cnt <= 10'h0;
        end else if (osc_run) begin
            psc_cnt <= psc_cnt + 10'h1;
        end
    end

    // ************************************
    // Prescale field, shared with Timer0
    // ************************************
    always @(posedge clk) begin
        if (reset | any_rst) begin
            // Slowest ratio after any reset
            timer0_prescale <= `T0M_RESET;
        end else if (apb_wr & sel_t0m) begin
            timer0_prescale <= pwdata[2:0];
        end
    end

    // ************************************
    // Watchdog down counter
    // ************************************
    // Reload is one value for every clock source; the base tick is clk
    always @(posedge clk) begin
        if (reset) begin
            dog_cnt <= DOG_BASE_CYCLES[16:0];
        end else if (any_rst | restart) begin
            dog_cnt <= DOG_BASE_CYCLES[16:0];
        // Held full through warm-up, so RUN starts fresh
        end else if ((state == `ST_WARM) | stop_wake) begin
            dog_cnt <= DOG_BASE_CYCLES[16:0];
        // Frozen outside RUN and HALT
        end else if (dog_live & psc_tick) begin
            dog_cnt <= dog_cnt - 17'h1;
        end
    end

    // ************************************
    // Reset-cause flag
    // ************************************
    always @(posedge clk) begin
        if (reset) begin
            dog_flag <= `FLAG_RESET;
        // Pad wins over a same-cycle overflow
        end else if (pad_reset) begin
            dog_flag <= 1'b1;
        end else if (dog_over) begin
            dog_flag <= 1'b0;
        // A STOP wake is never a watchdog cause
        end else if (stop_wake) begin
            dog_flag <= 1'b1;
        end
    end

    // ************************************
    // Mode sequencer
    // ************************************
    // Options are caught while reset is held, so software cannot alter them
    always @(posedge clk) begin
        if (reset) begin
            dog_en      <= dog_enable_opt;
            clk_opt     <= clock_source_option;
            state       <= `ST_WARM;
            // Option pins, since clk_opt is still being caught
            if (clock_source_option[`CLK_OPT_RC_BIT]) begin
                warm_cnt <= WARM_POR_RC[14:0];
            end else begin
                warm_cnt <= WARM_POR_XTAL[14:0];
            end
            from_stop   <= 1'b0;
            core_reset  <= 1'b1;
            cpu_run     <= 1'b0;
            periph_run  <= 1'b0;
            osc_run     <= 1'b1;
            wake_to_isr <= 1'b0;
        end else if (any_rst) begin
            // Watchdog reset reuses the pad-reset warm-up length
            state       <= `ST_WARM;
            if (is_rc) begin
                warm_cnt <= WARM_PAD_RC[14:0];
            end else begin
                warm_cnt <= WARM_PAD_XTAL[14:0];
            end
            from_stop   <= 1'b0;
            core_reset  <= 1'b1;
            cpu_run     <= 1'b0;
            periph_run  <= 1'b0;
            osc_run     <= 1'b1;
            wake_to_isr <= 1'b0;
        end else begin
            wake_to_isr <= 1'b0;
            // Strobe by default; set only at the end of a wake
            case (state)
                `ST_WARM: begin
                    osc_run <= 1'b1;
                    // Release the core once the count is spent
                    if (warm_cnt != 15'h0) begin
                        warm_cnt <= warm_cnt - 15'h1;
                    end else begin
                        state       <= `ST_RUN;
                        core_reset  <= 1'b0;
                        cpu_run     <= 1'b1;
                        periph_run  <= 1'b1;
                        wake_to_isr <= from_stop;
                        from_stop   <= 1'b0;
                    end
                end
                `ST_RUN: begin
                    // STOP wins when both strobes come together
                    if (stop_exec) begin
                        state      <= `ST_STOP;
                        cpu_run    <= 1'b0;
                        periph_run <= 1'b0;
                        osc_run    <= 1'b0;
                    end else if (halt_exec) begin
                        state   <= `ST_HALT;
                        cpu_run <= 1'b0;
                    end
                end
                `ST_HALT: begin
                    // Timers run on; only the core waits
                    if (halt_wake) begin
                        state       <= `ST_RUN;
                        cpu_run     <= 1'b1;
                        wake_to_isr <= 1'b1;
                    end
                end
                `ST_STOP: begin
                    // Oscillator restarts only for port or external
                    if (stop_wake) begin
                        state     <= `ST_WARM;
                        osc_run   <= 1'b1;
                        from_stop <= 1'b1;
                        if (is_rc) begin
                            warm_cnt <= WARM_STOP_RC[14:0];
                        end else begin
                            warm_cnt <= WARM_STOP_XTAL[14:0];
                        end
                    end
                end
                default: begin
                    state <= `ST_WARM;
                end
            endcase
        end
    end

    // ************************************
    // APB read mux
    // ************************************
    always @* begin
        next_prdata = 32'h0;
        addr_hit    = 1'b1;
        if (sel_t0m) begin
            next_prdata[2:0] = timer0_prescale;
        end else if (sel_dog) begin
            next_prdata[`DOG_RESTART_BIT] = dog_flag;
        end else if (sel_stat) begin
            next_prdata[1:0] = state;
            next_prdata[2]   = dog_en;
            next_prdata[3]   = is_rc;
        end else begin
            // Unmapped or unaligned: refused, reads zero
            addr_hit = 1'b0;
        end
    end

    // ************************************
    // APB handshake
    // ************************************
    // One wait state: pready rises in the second access cycle
    always @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel & penable & ~pready) begin
            pready  <= 1'b1;
            // Error only ever rises together with pready
            pslverr <= ~addr_hit;
            prdata  <= pwrite ? 32'h0 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // watchdog_sleep_warmup_ctrl

`default_nettype wire

// >>> sim/cpu_sleep_model.sv
/* CPU-side model: issues HALT and STOP pulses on bench request.
   Assumes one-cycle requests from the bench and a steady cpu_run. */
`timescale 1ns/1ps
`default_nettype none
module cpu_sleep_model (
    // Clock and run state
    input  wire logic clk,
    input  wire logic cpu_run,
    // Bench requests
    input  wire logic req_halt,
    input  wire logic req_stop,
    // Sleep instructions
    output var logic  halt_exec = 1'h0,
    output var logic  stop_exec = 1'h0
);
    // A stopped CPU executes nothing, so requests only land while running
    always @(posedge clk) begin
        halt_exec <= req_halt && cpu_run;
        stop_exec <= req_stop && cpu_run;
    end
endmodule // cpu_sleep_model
`default_nettype wire

// >>> sim/watchdog_sleep_warmup_ctrl_properties.sv
/* Port-level checks of the watchdog controller.
   Assumes the bind below and options held steady after reset. */
`timescale 1ns/1ps
`default_nettype none
module wsw_properties #(
    parameter WARM_POR_XTAL = 16,
    parameter WARM_POR_RC   = 8
) (
    // Clock, resets and interrupts
    input wire logic       clk, reset, pad_reset, any_irq, port_irq, ext_irq,
    input wire logic [1:0] clock_source_option,
    // Handshakes
    input wire logic       halt_exec, stop_exec, psel, penable, pready, pslverr,
    // Device control
    input wire logic       core_reset, cpu_run, periph_run, osc_run, wake_to_isr
);
    localparam int WX = WARM_POR_XTAL;
    localparam int WR = WARM_POR_RC;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ************************
    // Assertions
    // ************************
    sequence warm_done;
        core_reset ##1 !core_reset && cpu_run;
    endsequence
    sequence in_halt;
        periph_run && !cpu_run && !pad_reset;
    endsequence
    por_rc_a: assert property (
        $fell(reset) && clock_source_option[1] |-> ##WR warm_done) else $error("RC warm-up");
    por_xtal_a: assert property (
        $fell(reset) && !clock_source_option[1] |-> ##WX warm_done) else $error("XT warm-up");
    halt_enter_a: assert property (
        cpu_run && halt_exec && !stop_exec && !pad_reset |=> !cpu_run && periph_run && osc_run)
        else $error("HALT entry wrong");
    stop_enter_a: assert property (
        cpu_run && stop_exec && !pad_reset |=> !cpu_run && !periph_run && !osc_run)
        else $error("STOP entry wrong");
    stop_hold_a: assert property (
        !osc_run && !port_irq && !ext_irq && !pad_reset |=> !osc_run && !core_reset)
        else $error("STOP left without cause");
    stop_wake_a: assert property (
        !osc_run && (port_irq || ext_irq) && !pad_reset |=> osc_run && !cpu_run ##1 !cpu_run)
        else $error("STOP wake-up wrong");
    halt_wake_a: assert property (in_halt ##0 any_irq |=> cpu_run && wake_to_isr)
        else $error("HALT wake-up wrong");
    isr_pulse_a: assert property (wake_to_isr |=> !wake_to_isr)
        else $error("service pulse too long");
    apb_answer_a: assert property (
        $rose(penable) && psel |-> !pready ##1 pready ##1 !pready) else $error("APB timing");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
endmodule // wsw_properties
bind watchdog_sleep_warmup_ctrl wsw_properties #(
    .WARM_POR_XTAL(WARM_POR_XTAL), .WARM_POR_RC(WARM_POR_RC)) props (
    .clk(clk), .reset(reset), .pad_reset(pad_reset), .any_irq(any_irq),
    .port_irq(port_irq), .ext_irq(ext_irq), .clock_source_option(clock_source_option),
    .halt_exec(halt_exec), .stop_exec(stop_exec), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .core_reset(core_reset), .cpu_run(cpu_run),
    .periph_run(periph_run), .osc_run(osc_run), .wake_to_isr(wake_to_isr));
`default_nettype wire

// >>> sim/tb_watchdog_sleep_warmup_ctrl.sv
/* Self-checking bench for the watchdog controller.
   Assumes the CPU model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_sleep_warmup_ctrl;
    localparam int DOG = 20, PX = 16, PR = 8, DX = 10, DR = 4, SX = 12, SR = 6;
    logic        clk = 0, reset = 1, pad_reset = 0, dog_enable_opt = 1;
    logic        any_irq = 0, port_irq = 0, ext_irq = 0, req_halt = 0, req_stop = 0;
    logic        psel = 0, penable = 0, pwrite = 0, rerr;
    logic [1:0]  clock_source_option = 2'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        halt_exec, stop_exec, pready, pslverr, core_reset, cpu_run;
    logic        periph_run, osc_run, wake_to_isr;
    logic [2:0]  timer0_prescale;
    int          err_count = 0, n_checks = 0, n;
    int          ratio [8] = '{1024, 512, 128, 32, 8, 4, 2, 1};
    always #4 clk = ~clk;
    cpu_sleep_model cpu (.clk(clk), .cpu_run(cpu_run), .req_halt(req_halt),
        .req_stop(req_stop), .halt_exec(halt_exec), .stop_exec(stop_exec));
    watchdog_sleep_warmup_ctrl #(.DOG_BASE_CYCLES(DOG), .WARM_POR_XTAL(PX), .WARM_POR_RC(PR),
        .WARM_PAD_XTAL(DX), .WARM_PAD_RC(DR), .WARM_STOP_XTAL(SX), .WARM_STOP_RC(SR)) uut (
        .clk(clk), .reset(reset), .pad_reset(pad_reset), .dog_enable_opt(dog_enable_opt),
        .clock_source_option(clock_source_option), .halt_exec(halt_exec),
        .stop_exec(stop_exec), .any_irq(any_irq), .port_irq(port_irq), .ext_irq(ext_irq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_reset(core_reset),
        .cpu_run(cpu_run), .periph_run(periph_run), .osc_run(osc_run),
        .wake_to_isr(wake_to_isr), .timer0_prescale(timer0_prescale));
    // ************************
    // Shared tasks
    // ************************
    task print_verdict;
        if (err_count == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        if (i >= 20) chk(0, 1);
    endtask
    // Counts edges until cpu_run (0) or core_reset (1) is seen high
    task wait_on(input int sel);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((sel == 0 ? cpu_run : core_reset) !== 1'b1 && n < 30000);
    endtask
    task do_reset(input logic en, input logic [1:0] cs, input int exp);
        @(posedge clk);
        reset <= 1;
        dog_enable_opt <= en;
        clock_source_option <= cs;
        repeat (10) @(posedge clk);
        reset <= 0;
        wait_on(0);
        chk(n, exp + 2);
    endtask
    // ************************
    // Scenarios
    // ************************
    task t_regs;
        apb(0, 12'h008, 0);
        chk(rd, 0);
        apb(1, 12'h068, 0);
        apb(0, 12'h068, 0);
        chk(rd, 32'h8);
        apb(1, 12'h008, 32'hd);
        @(posedge clk);
        chk(timer0_prescale, 3'h5);
        apb(0, 12'h100, 0);
        chk(rerr, 1);
        chk(rd, 0);
    endtask
    task t_dog;
        int c;
        apb(1, 12'h008, 32'h7);
        repeat (8) apb(1, 12'h068, 32'hf);
        apb(0, 12'h068, 0);
        chk(rd, 32'h8);
        for (c = 7; c >= 0; c--) begin
            apb(1, 12'h008, c);
            apb(1, 12'h068, 32'h8);
            wait_on(1);
            chk(n >= 20 * ratio[c] + 1 && n <= 21 * ratio[c] + 3, 1);
            wait_on(0);
            apb(0, 12'h068, 0);
            chk(rd, 0);
        end
    endtask
    task t_pad(input int exp);
        pad_reset <= 1;
        repeat (3) @(posedge clk);
        pad_reset <= 0;
        wait_on(0);
        chk(n, exp + 2);
        apb(0, 12'h068, 0);
        chk(rd, 32'h8);
    endtask
    task t_stop(input logic use_ext, input int exp);
        apb(1, 12'h008, 32'h7);
        apb(1, 12'h068, 32'h8);
        repeat (8) @(posedge clk);
        req_stop <= 1;
        @(posedge clk);
        req_stop <= 0;
        repeat (40) @(posedge clk);
        chk({osc_run, core_reset}, 0);
        any_irq <= 1;
        repeat (4) @(posedge clk);
        chk(osc_run, 0);
        port_irq <= !use_ext;
        ext_irq <= use_ext;
        wait_on(0);
        chk(n, exp + 3);
        any_irq <= 0;
        port_irq <= 0;
        ext_irq <= 0;
        repeat (14) @(posedge clk);
        apb(0, 12'h068, 0);
        chk(rd, 32'h8);
    endtask
    task t_halt;
        apb(1, 12'h008, 32'h7);
        req_halt <= 1;
        @(posedge clk);
        req_halt <= 0;
        repeat (40) @(posedge clk);
        chk({cpu_run, periph_run, core_reset}, 3'h2);
        any_irq <= 1;
        wait_on(0);
        chk(n, 2);
        any_irq <= 0;
    endtask
    initial begin
        do_reset(1, 2'h0, PX);
        t_regs;
        t_dog;
        t_pad(DX);
        t_stop(0, SX);
        do_reset(0, 2'h2, PR);
        t_halt;
        t_stop(1, SR);
        t_pad(DR);
        do_reset(1, 2'h3, PR);
        print_verdict;
    end
    initial begin
        #(8 * 90000);
        err_count++;
        print_verdict;
    end
endmodule // tb_watchdog_sleep_warmup_ctrl
`default_nettype wire
